// ==== rtl/mlsx_pkg.sv ====
`default_nettype none
package mlsx_pkg;
    localparam logic [5:0] OP_SPECIAL   = 6'h00;
    localparam logic [5:0] OP_IMM_OR    = 6'h0d;
    localparam logic [5:0] OP_COP0      = 6'h10;
    localparam logic [5:0] OP_BYTE_ST   = 6'h28;
    localparam logic [5:0] OP_HALF_ST   = 6'h29;
    localparam logic [5:0] FN_IMM_SLL   = 6'h00;
    localparam logic [5:0] FN_VAR_SLL   = 6'h04;
    localparam logic [5:0] FN_DBG_BRK   = 6'h0e;
    localparam logic [5:0] FN_MUL_S     = 6'h18;
    localparam logic [5:0] FN_MUL_U     = 6'h19;
    localparam logic [5:0] FN_OR        = 6'h25;
    localparam logic [5:0] FN_NOR       = 6'h27;
    localparam logic [5:0] FN_EXC_RET   = 6'h10;
    localparam int         OPC_MSB      = 31;
    localparam int         SRCA_LSB     = 21;
    localparam int         SRCB_LSB     = 16;
    localparam int         DEST_LSB     = 11;
    localparam int         SHAMT_LSB    = 6;
    localparam int         COBIT_POS    = 25;
    localparam logic [5:0] MODE_RST     = 6'h00;
    localparam logic [31:0] WORD_RST    = 32'h0000_0000;
    typedef enum logic [1:0] {
        MLSX_ST_NONE,
        MLSX_ST_BYTE,
        MLSX_ST_HALF
    } mlsx_store_t;
endpackage
`default_nettype wire

// ==== rtl/mlsx_mode_stack.sv ====
`default_nettype none
// three-deep mode stack; pop moves prev->now and old->prev
module mlsx_mode_stack (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pop,
    input  wire logic push_en,
    input  wire logic now_in,
    input  wire logic prev_in,
    input  wire logic old_in,
    output logic      now_q,
    output logic      prev_q,
    output logic      old_q
);
    logic [2:0] st_r;
    logic [2:0] st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (push_en) begin
            st_nxt = {old_in, prev_in, now_in};
        end else if (pop) begin
            st_nxt = {st_r[2], st_r[2], st_r[1]};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= 3'h0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign now_q  = st_r[0];
    assign prev_q = st_r[1];
    assign old_q  = st_r[2];
endmodule
`default_nettype wire

// ==== rtl/mlsx_exec.sv ====
`default_nettype none
// Functional notes
// - signed multiply, full product, no overflow
// - product low to bottom and dest, high upper
// - unsigned multiply zero-extends operands, no overflow
// - nor of sources into destination, no exception
// - or of sources into destination, no exception
// - immediate or zero-extends, writes second field
// - exception return pops irq and privilege stack
// - exception return pops cache autolock stacks
// - byte store: base plus signed offset
// - address invert, lane xor, data shift
// - halfword store, odd address raises error
// - debug break raises exception, code ignored
// - immediate left shift, zero fill
// - variable left shift by source low bits
// - only address error raised for stores
module mlsx_exec (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        instr_valid,
    input  wire logic [31:0] instr,
    input  wire logic [31:0] src_a_val,
    input  wire logic [31:0] src_b_val,
    input  wire logic        swapped_order_flag,
    input  wire logic        msb_first_core,
    input  wire logic        mode_load,
    input  wire logic [5:0]  mode_load_val,
    output logic             wr_en,
    output logic [4:0]       wr_addr,
    output logic [31:0]      wr_data,
    output logic [31:0]      upper_product_reg,
    output logic [31:0]      bottom_product_reg,
    output logic             st_en,
    output logic [31:0]      st_addr,
    output logic [31:0]      virtual_addr,
    output logic [31:0]      st_data,
    output logic [3:0]       st_lanes,
    output logic             addr_err,
    output logic             debug_break,
    output logic             irq_mask_now,
    output logic             irq_mask_prev,
    output logic             irq_mask_old,
    output logic             priv_now,
    output logic             priv_prev,
    output logic             priv_old,
    output logic             dcache_autolock_now,
    output logic             dcache_autolock_prev,
    output logic             dcache_autolock_old,
    output logic             icache_autolock_now,
    output logic             icache_autolock_prev,
    output logic             icache_autolock_old
);
    ////////////////////////////////////////////////////////////////
    logic [5:0]  opc;
    logic [5:0]  fn;
    logic [4:0]  source_a_field;
    logic [4:0]  source_b_field;
    logic [4:0]  dest_field;
    logic [4:0]  shift_amount_field;
    logic [15:0] imm;
    logic        special;
    logic        signed_product_op;
    logic        unsigned_product_op;
    logic        exception_return_op;
    logic        byte_store_op;
    logic        half_store_op;
    logic [63:0] prod;
    logic signed [65:0] prod_full;
    logic [31:0] ea;
    logic [1:0]  lane;
    logic [1:0]  pa_lo;

    assign opc                = instr[mlsx_pkg::OPC_MSB -: 6];
    assign fn                 = instr[5:0];
    assign source_a_field     = instr[mlsx_pkg::SRCA_LSB +: 5];
    assign source_b_field     = instr[mlsx_pkg::SRCB_LSB +: 5];
    assign dest_field         = instr[mlsx_pkg::DEST_LSB +: 5];
    assign shift_amount_field = instr[mlsx_pkg::SHAMT_LSB +: 5];
    assign imm                = instr[15:0];
    assign special            = instr_valid && (opc == mlsx_pkg::OP_SPECIAL);
    assign signed_product_op   = special && (fn == mlsx_pkg::FN_MUL_S);
    assign unsigned_product_op = special && (fn == mlsx_pkg::FN_MUL_U);
    assign exception_return_op = instr_valid && (opc == mlsx_pkg::OP_COP0) && instr[mlsx_pkg::COBIT_POS]
                                 && (fn == mlsx_pkg::FN_EXC_RET);
    assign byte_store_op       = instr_valid && (opc == mlsx_pkg::OP_BYTE_ST);
    assign half_store_op       = instr_valid && (opc == mlsx_pkg::OP_HALF_ST);

    // one 33x33 signed multiplier serves both forms; 66-bit target keeps the product exact
    assign prod_full = $signed({signed_product_op & src_a_val[31], src_a_val})
                     * $signed({signed_product_op & src_b_val[31], src_b_val});
    assign prod      = prod_full[63:0];
    assign ea   = src_a_val + {{16{imm[15]}}, imm};
    assign lane = ea[1:0] ^ (byte_store_op ? {2{msb_first_core}} : {msb_first_core, 1'b0});
    assign pa_lo = ea[1:0] ^ (byte_store_op ? {2{swapped_order_flag}} : {swapped_order_flag, 1'b0});

    ////////////////////////////////////////////////////////////////
    logic        wr_en_r,   wr_en_nxt;
    logic [4:0]  wr_addr_r, wr_addr_nxt;
    logic [31:0] wr_data_r, wr_data_nxt;
    logic [31:0] hi_r,      hi_nxt;
    logic [31:0] lo_r,      lo_nxt;
    logic        st_en_r,   st_en_nxt;
    logic [31:0] st_addr_r, st_addr_nxt;
    logic [31:0] va_r,      va_nxt;
    logic [31:0] st_data_r, st_data_nxt;
    logic [3:0]  lanes_r,   lanes_nxt;
    logic        aerr_r,    aerr_nxt;
    logic        dbg_r,     dbg_nxt;

    always_comb begin
        wr_en_nxt   = 1'b0;
        wr_addr_nxt = 5'h00;
        wr_data_nxt = wr_data_r;
        hi_nxt      = hi_r;
        lo_nxt      = lo_r;
        st_en_nxt   = 1'b0;
        st_addr_nxt = st_addr_r;
        va_nxt      = va_r;
        st_data_nxt = st_data_r;
        lanes_nxt   = 4'h0;
        aerr_nxt    = 1'b0;
        dbg_nxt     = 1'b0;
        if (signed_product_op || unsigned_product_op) begin
            lo_nxt      = prod[31:0];
            hi_nxt      = prod[63:32];
            wr_data_nxt = prod[31:0];
            wr_addr_nxt = dest_field;
            wr_en_nxt   = (dest_field != 5'h00);
        end else if (special) begin
            wr_addr_nxt = dest_field;
            wr_en_nxt   = 1'b1;
            case (fn)
                mlsx_pkg::FN_NOR:     wr_data_nxt = ~(src_a_val | src_b_val);
                mlsx_pkg::FN_OR:      wr_data_nxt = src_a_val | src_b_val;
                mlsx_pkg::FN_IMM_SLL: wr_data_nxt = src_b_val << shift_amount_field;
                mlsx_pkg::FN_VAR_SLL: wr_data_nxt = src_b_val << src_a_val[4:0];
                mlsx_pkg::FN_DBG_BRK: begin
                    wr_en_nxt = 1'b0;
                    dbg_nxt   = 1'b1;
                end
                default:              wr_en_nxt = 1'b0;
            endcase
        end else if (instr_valid && opc == mlsx_pkg::OP_IMM_OR) begin
            wr_en_nxt   = 1'b1;
            wr_addr_nxt = source_b_field;
            wr_data_nxt = src_a_val | {16'h0000, imm};
        end else if (byte_store_op || half_store_op) begin
            va_nxt = ea;
            if (half_store_op && ea[0]) begin
                aerr_nxt = 1'b1;
            end else begin
                // translation passes ea[31:2] through and xors the low bits with swapped_order_flag, so no refill faults arise
                st_en_nxt   = 1'b1;
                st_addr_nxt = {ea[31:2], pa_lo};
                // whole word shifted; lane enables pick the stored byte or halfword
                st_data_nxt = src_b_val << {lane, 3'b000};
                lanes_nxt   = (half_store_op ? 4'h3 : 4'h1) << lane;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_en_r   <= 1'b0;
            wr_addr_r <= 5'h00;
            wr_data_r <= mlsx_pkg::WORD_RST;
            hi_r      <= mlsx_pkg::WORD_RST;
            lo_r      <= mlsx_pkg::WORD_RST;
            st_en_r   <= 1'b0;
            st_addr_r <= mlsx_pkg::WORD_RST;
            va_r      <= mlsx_pkg::WORD_RST;
            st_data_r <= mlsx_pkg::WORD_RST;
            lanes_r   <= 4'h0;
            aerr_r    <= 1'b0;
            dbg_r     <= 1'b0;
        end else begin
            wr_en_r   <= wr_en_nxt;
            wr_addr_r <= wr_addr_nxt;
            wr_data_r <= wr_data_nxt;
            hi_r      <= hi_nxt;
            lo_r      <= lo_nxt;
            st_en_r   <= st_en_nxt;
            st_addr_r <= st_addr_nxt;
            va_r      <= va_nxt;
            st_data_r <= st_data_nxt;
            lanes_r   <= lanes_nxt;
            aerr_r    <= aerr_nxt;
            dbg_r     <= dbg_nxt;
        end
    end

    assign wr_en              = wr_en_r;
    assign wr_addr            = wr_addr_r;
    assign wr_data            = wr_data_r;
    assign upper_product_reg  = hi_r;
    assign bottom_product_reg = lo_r;
    assign st_en              = st_en_r;
    assign st_addr            = st_addr_r;
    assign virtual_addr       = va_r;
    assign st_data            = st_data_r;
    assign st_lanes           = lanes_r;
    assign addr_err           = aerr_r;
    assign debug_break        = dbg_r;

    ////////////////////////////////////////////////////////////////
    // mode_load_val: [0]irq [1]priv [2]dcache [3]icache now bits
    // [4] prev and [5] old are shared by all four stacks, seeding only
    mlsx_mode_stack u_irq (
        .clk     (clk),
        .rst     (rst),
        .pop     (exception_return_op),
        .push_en (mode_load),
        .now_in  (mode_load_val[0]),
        .prev_in (mode_load_val[4]),
        .old_in  (mode_load_val[5]),
        .now_q   (irq_mask_now),
        .prev_q  (irq_mask_prev),
        .old_q   (irq_mask_old)
    );
    mlsx_mode_stack u_priv (
        .clk     (clk),
        .rst     (rst),
        .pop     (exception_return_op),
        .push_en (mode_load),
        .now_in  (mode_load_val[1]),
        .prev_in (mode_load_val[4]),
        .old_in  (mode_load_val[5]),
        .now_q   (priv_now),
        .prev_q  (priv_prev),
        .old_q   (priv_old)
    );
    mlsx_mode_stack u_dal (
        .clk     (clk),
        .rst     (rst),
        .pop     (exception_return_op),
        .push_en (mode_load),
        .now_in  (mode_load_val[2]),
        .prev_in (mode_load_val[4]),
        .old_in  (mode_load_val[5]),
        .now_q   (dcache_autolock_now),
        .prev_q  (dcache_autolock_prev),
        .old_q   (dcache_autolock_old)
    );
    mlsx_mode_stack u_ial (
        .clk     (clk),
        .rst     (rst),
        .pop     (exception_return_op),
        .push_en (mode_load),
        .now_in  (mode_load_val[3]),
        .prev_in (mode_load_val[4]),
        .old_in  (mode_load_val[5]),
        .now_q   (icache_autolock_now),
        .prev_q  (icache_autolock_prev),
        .old_q   (icache_autolock_old)
    );
endmodule
`default_nettype wire

// ==== verification/mlsx_exec_props.sv ====
`default_nettype none
module mlsx_exec_props (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        instr_valid,
    input wire logic [31:0] instr,
    input wire logic [31:0] src_a_val,
    input wire logic [31:0] src_b_val,
    input wire logic        mode_load,
    input wire logic        wr_en,
    input wire logic [31:0] wr_data,
    input wire logic [31:0] upper_product_reg,
    input wire logic [31:0] bottom_product_reg,
    input wire logic        st_en,
    input wire logic        addr_err,
    input wire logic        debug_break,
    input wire logic        irq_mask_now,
    input wire logic        irq_mask_prev,
    input wire logic        irq_mask_old
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire logic [5:0]  fn = instr[5:0];
    wire logic        sp = instr_valid && instr[31:26] == 6'h00;
    wire logic        rd0 = instr[15:11] == 5'h00;
    // 64-bit widening keeps the whole product, low word alone would hide high-half slips
    wire logic [63:0] pu = {32'h0, src_a_val} * {32'h0, src_b_val};
    wire logic [63:0] ps = {{32{src_a_val[31]}}, src_a_val} * {{32{src_b_val[31]}}, src_b_val};
    ////////////////////////////////////////////////////////////////////////////
    property p_nor;
        sp && fn == 6'h27 && !rd0 |=> wr_en && wr_data == ~($past(src_a_val) | $past(src_b_val));
    endproperty
    property p_or;
        sp && fn == 6'h25 && !rd0 |=> wr_en && wr_data == ($past(src_a_val) | $past(src_b_val));
    endproperty
    property p_muls; sp && fn == 6'h18 |=> {upper_product_reg, bottom_product_reg} == $past(ps); endproperty
    property p_mulu; sp && fn == 6'h19 |=> {upper_product_reg, bottom_product_reg} == $past(pu); endproperty
    property p_mul0; sp && (fn == 6'h18 || fn == 6'h19) && rd0 |=> !wr_en; endproperty
    property p_odd;
        instr_valid && instr[31:26] == 6'h29 && (src_a_val[0] ^ instr[0]) |=> addr_err && !st_en;
    endproperty
    property p_brk; sp && fn == 6'h0e |=> debug_break && !wr_en && !st_en; endproperty
    property p_ret;
        instr_valid && instr[31:26] == 6'h10 && instr[25] && fn == 6'h10 && !mode_load |=>
            irq_mask_now == $past(irq_mask_prev) && irq_mask_prev == $past(irq_mask_old) && $stable(irq_mask_old);
    endproperty
    ////////////////////////////////////////////////////////////////////////////
    a_nor: assert property (p_nor) else $error("nor result wrong");
    a_or: assert property (p_or) else $error("or result wrong");
    a_muls: assert property (p_muls) else $error("signed product wrong");
    a_mulu: assert property (p_mulu) else $error("unsigned product wrong");
    a_mul0: assert property (p_mul0) else $error("write to register zero");
    a_odd: assert property (p_odd) else $error("odd halfword store not refused");
    a_brk: assert property (p_brk) else $error("breakpoint not raised");
    a_ret: assert property (p_ret) else $error("mode stack pop wrong");
    c_mulu0: cover property (sp && fn == 6'h19 && rd0);
    c_odd: cover property (addr_err);
    c_brk: cover property (debug_break);
endmodule
bind mlsx_exec mlsx_exec_props mlsx_exec_props_inst (.clk, .rst, .instr_valid, .instr, .src_a_val, .src_b_val,
    .mode_load, .wr_en, .wr_data, .upper_product_reg, .bottom_product_reg, .st_en, .addr_err, .debug_break,
    .irq_mask_now, .irq_mask_prev, .irq_mask_old);
`default_nettype wire

// ==== verification/mlsx_core_model.sv ====
`default_nettype none
// pipeline side: keeps issued words; break code is never decoded by the core
module mlsx_core_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        instr_valid,
    input  wire logic [31:0] instr,
    input  wire logic        debug_break,
    output logic      [19:0] brk_code
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] imem [0:63];
    logic [5:0]  pc_r;
    logic [5:0]  debug_return_pc;
    always_ff @(posedge clk) begin
        if (rst) begin
            pc_r <= 6'h00;
            brk_code <= 20'h00000;
        end else begin
            if (instr_valid) begin
                imem[pc_r] <= instr;
                debug_return_pc <= pc_r;
                pc_r <= pc_r + 6'h01;
            end
            // handler refetches the word; only valid while no newer word is issued
            if (debug_break) brk_code <= imem[debug_return_pc][25:6];
        end
    end
endmodule
`default_nettype wire

// ==== verification/mlsx_exec_test.sv ====
`default_nettype none
module mlsx_exec_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'h0, rst = 1'h1, instr_valid = 1'h0, mode_load = 1'h0;
    logic        swapped_order_flag = 1'h0, msb_first_core = 1'h0;
    logic [31:0] instr = 32'h0, src_a_val = 32'h0, src_b_val = 32'h0;
    logic [5:0]  mode_load_val = 6'h00;
    logic        wr_en, st_en, addr_err, debug_break, irq_mask_now, irq_mask_prev, irq_mask_old;
    logic        priv_now, priv_prev, priv_old, dcache_autolock_now, dcache_autolock_prev, dcache_autolock_old;
    logic        icache_autolock_now, icache_autolock_prev, icache_autolock_old;
    logic [4:0]  wr_addr;
    logic [3:0]  st_lanes;
    logic [19:0] brk_code;
    logic [31:0] wr_data, upper_product_reg, bottom_product_reg, st_addr, virtual_addr, st_data;
    int          n_mismatch = 0, checks = 0;
    always #5 clk = ~clk;
    mlsx_exec mlsx_exec_inst (.clk, .rst, .instr_valid, .instr, .src_a_val, .src_b_val, .swapped_order_flag,
        .msb_first_core, .mode_load, .mode_load_val, .wr_en, .wr_addr, .wr_data, .upper_product_reg,
        .bottom_product_reg, .st_en, .st_addr, .virtual_addr, .st_data, .st_lanes, .addr_err, .debug_break,
        .irq_mask_now, .irq_mask_prev, .irq_mask_old, .priv_now, .priv_prev, .priv_old, .dcache_autolock_now,
        .dcache_autolock_prev, .dcache_autolock_old, .icache_autolock_now, .icache_autolock_prev,
        .icache_autolock_old);
    mlsx_core_model mlsx_core_model_inst (.clk, .rst, .instr_valid, .instr, .debug_break, .brk_code);
    ////////////////////////////////////////////////////////////////////////////
    // wide enough for the packed groups compared below, so no field is cut off
    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // valid stays high between calls, so back-to-back words are really exercised
    task automatic issue(input logic [31:0] i, input logic [31:0] a, input logic [31:0] b);
        instr = i;
        src_a_val = a;
        src_b_val = b;
        instr_valid = 1'h1;
        @(posedge clk);
        #1;
    endtask
    task automatic done(input string name);
        instr_valid = 1'h0;
        @(posedge clk);
        #1 $display("test %s finished", name);
    endtask
    function automatic logic [31:0] spec(input logic [5:0] fn, input logic [4:0] d, input logic [4:0] s);
        return {6'h00, 10'h022, d, s, fn};
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_logic;
        issue(spec(6'h27, 5'h03, 5'h00), 32'hf0f0_0000, 32'h0000_00ff);
        chk({wr_en, wr_addr, wr_data}, {1'h1, 5'h03, 32'h0f0f_ff00});
        issue(spec(6'h25, 5'h03, 5'h00), 32'hf0f0_0000, 32'h0000_00ff);
        chk(wr_data, 32'hf0f0_00ff);
        issue({6'h0d, 10'h027, 16'h8001}, 32'hf0f0_0f00, 32'h0);
        chk({wr_en, wr_addr, wr_data}, {1'h1, 5'h07, 32'hf0f0_8f01});
        done("logic");
    endtask
    task automatic t_mul;
        issue(spec(6'h18, 5'h05, 5'h00), 32'hffff_fffd, 32'h0000_0007);
        chk(upper_product_reg, 32'hffff_ffff);
        chk({wr_en, wr_addr, wr_data, bottom_product_reg}, {6'h25, 64'hffff_ffeb_ffff_ffeb});
        issue(spec(6'h19, 5'h00, 5'h00), 32'hffff_ffff, 32'h0000_0002);
        chk({upper_product_reg, bottom_product_reg}, 64'h1_ffff_fffe);
        chk(wr_en, 32'h0);
        done("multiply");
    endtask
    task automatic t_shift;
        issue(spec(6'h00, 5'h09, 5'h1f), 32'h0, 32'h0000_0003);
        chk(wr_data, 32'h8000_0000);
        issue(spec(6'h04, 5'h09, 5'h00), 32'hffff_ffe4, 32'h0000_00f1);
        chk(wr_data, 32'h0000_0f10);
        done("shift");
    endtask
    task automatic t_store;
        issue({6'h28, 10'h022, 16'h0001}, 32'h100, 32'h1234_56ab);
        chk({st_en, st_lanes, st_addr, st_data}, {5'h12, 64'h0000_0101_3456_ab00});
        msb_first_core = 1'h1;
        swapped_order_flag = 1'h1;
        issue({6'h28, 10'h022, 16'hfffd}, 32'h100, 32'h1234_56ab);
        chk(virtual_addr, 32'h0000_00fd);
        chk({st_en, st_lanes, st_addr, st_data}, {5'h14, 64'h0000_00fe_56ab_0000});
        issue({6'h29, 10'h022, 16'h0002}, 32'h100, 32'h1234_56ab);
        chk({st_en, st_lanes, st_addr, st_data}, {5'h13, 64'h0000_0100_1234_56ab});
        issue({6'h29, 10'h022, 16'hffff}, 32'h102, 32'h1234_56ab);
        chk({st_en, addr_err}, 32'h1);
        done("store");
    endtask
    task automatic t_brk;
        issue({6'h00, 20'habcde, 6'h0e}, 32'h0, 32'h0);
        chk({debug_break, wr_en, st_en}, 32'h4);
        done("breakpoint");
        chk(brk_code, 32'habcde);
    endtask
    task automatic t_ret;
        mode_load = 1'h1;
        mode_load_val = 6'h20;
        @(posedge clk);
        #1 mode_load = 1'h0;
        issue({6'h10, 1'h1, 19'h0, 6'h10}, 32'h0, 32'h0);
        chk({irq_mask_now, irq_mask_prev, irq_mask_old, priv_now, priv_prev, priv_old}, 32'h1b);
        chk({dcache_autolock_now, dcache_autolock_prev, dcache_autolock_old, icache_autolock_now,
             icache_autolock_prev, icache_autolock_old}, 32'h1b);
        issue({6'h10, 1'h1, 19'h0, 6'h10}, 32'h0, 32'h0);
        chk({irq_mask_now, priv_now, dcache_autolock_now, icache_autolock_now}, 32'hf);
        done("return");
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        #1 rst = 1'h0;
        t_logic;
        t_mul;
        t_shift;
        t_store;
        t_brk;
        t_ret;
        complete_run;
    end
    initial begin
        #5000;
        n_mismatch++;
        complete_run;
    end
endmodule
`default_nettype wire
